// file: rtl/phy_mii_mgmt.sv
// PHY side of the MII status pins and serial management channel
`timescale 1ns/100ps
`default_nettype none
module phy_mii_mgmt
   import phy_pkg::*;
#(
   parameter logic [4:0] PHY_ADDR       = 5'h00,
   parameter int         RST_EXT_CYCLES = phy_pkg::RST_EXT_CYC
) (
   // Clock and reset
   input  wire logic              clk_i,
   input  wire logic              arst_n_i,
   // Register bus
   input  wire phy_pkg::avs_req_t bus_i,
   output phy_pkg::avs_rsp_t      bus_o,
   output logic                   irq_o,
   // Pins from MAC, station and line
   input  wire phy_pkg::pins_t    pins_i,
   output phy_pkg::mii_out_t      mii_o
);
   import phy_pkg::*;

   localparam int RCW = $clog2(RST_EXT_CYCLES + 1);
   localparam logic [RCW-1:0] RST_LAST = RCW'(RST_EXT_CYCLES - 1);

   typedef struct packed {
      avs_rsp_t       rsp;
      mii_out_t       pins;
      logic           irq;
      logic [EV_W-1:0] ev_stat;
      logic [EV_W-1:0] ev_mask;
      logic           sw_reset;
      logic           rst_bit;
      logic           ireset;
      logic [RCW-1:0] rst_cnt;
      logic           speed100;
      logic           full_duplex;
      logic           irq_en;
      logic           pend;
      logic           link_q;
      logic           col_q;
      logic           mdc_q;
      logic [3:0]     div;
      mstate_t        ms;
      logic [5:0]     cnt;
      logic [15:0]    sh;
      logic           rd_ok;
      logic           wr_ok;
      logic [4:0]     reg_a;
   } st_t;

   st_t   st;
   st_t   next_st;
   pins_t pin_q;

   // All pins cross into the clock domain here
   pin_sync #(
      .W ($bits(pins_t))
   ) u_sync (
      .clk_i    (clk_i),
      .arst_n_i (arst_n_i),
      .d_i      (pins_i),
      .q_o      (pin_q)
   );

   // Read view of the management registers
   function automatic logic [15:0] mii_read(input st_t s, input logic [4:0] a);
      logic [15:0] v;
      v = '0;
      unique case (a)
         MREG_CTRL: begin
            v[CTRL_RST_BIT]    = s.ireset;
            v[CTRL_SPEED_BIT]  = s.speed100;
            v[CTRL_DUPLEX_BIT] = s.full_duplex;
         end
         MREG_STAT: begin
            v[STAT_LINK_BIT] = s.link_q;
         end
         MREG_IRQ_EN: begin
            v[IRQ_EN_BIT] = s.irq_en;
         end
         MREG_IRQ_STAT: begin
            v[IRQ_PEND_BIT] = s.pend;
         end
         default: begin
            v = '0;
         end
      endcase
      return v;
   endfunction

   always_comb begin
      logic [EV_W-1:0] ev;
      logic [3:0]      half;
      logic            rx_rise;
      logic            mdc_rise;
      logic            col_now;
      logic            crs_act;
      logic [12:0]     hdr;
      logic            ok;
      logic [15:0]     wd;
      ev       = '0;
      half     = HALF_SLOW;
      rx_rise  = 1'b0;
      mdc_rise = 1'b0;
      col_now  = 1'b0;
      crs_act  = 1'b0;
      hdr      = '0;
      ok       = 1'b0;
      wd       = '0;
      next_st  = st;

      // Reset pin ORed with the control bit; bit requests act once
      if (!pin_q.rst_pin_n || st.rst_bit || st.sw_reset) begin // [RQ14]
         next_st.ireset   = 1'b1;
         next_st.rst_cnt  = '0;
         next_st.rst_bit  = 1'b0;
         next_st.sw_reset = 1'b0;
      end else if (st.ireset) begin
         if (st.rst_cnt == RST_LAST) begin // [RQ14]
            next_st.ireset = 1'b0;
            ev[EV_RDONE]   = 1'b1;
         end else begin
            next_st.rst_cnt = st.rst_cnt + 1'b1;
         end
      end

      // Receive and transmit clock divider
      half = st.speed100 ? HALF_FAST : HALF_SLOW; // [RQ2]
      // At or past the limit, so a speed change mid-count
      // takes effect at once instead of wrapping the counter
      if (st.div >= half - 4'h1) begin
         next_st.div         = '0;
         next_st.pins.rx_clk = ~st.pins.rx_clk; // [RQ2]
         next_st.pins.tx_clk = ~st.pins.tx_clk;
         rx_rise             = ~st.pins.rx_clk;
      end else begin
         next_st.div = st.div + 4'h1;
      end

      // Collision: both directions busy, half duplex only
      col_now = ~st.full_duplex & pin_q.tx_en & pin_q.rx_carrier & ~st.ireset; // [RQ4]
      next_st.pins.col = col_now; // [RQ3]
      next_st.col_q    = col_now;
      ev[EV_COL]       = col_now & ~st.col_q;

      // Carrier sense rises at once, falls on a receive clock edge
      crs_act = pin_q.rx_carrier | (~st.full_duplex & pin_q.tx_en); // [RQ5] [RQ6]
      if (crs_act) begin
         next_st.pins.crs = 1'b1;
      end else if (rx_rise) begin
         next_st.pins.crs = 1'b0; // [RQ7]
      end

      // Transmit error seen while the MAC is sending
      ev[EV_TXER] = pin_q.tx_er & pin_q.tx_en; // [RQ1]

      // Line status change raises the management interrupt
      next_st.link_q = pin_q.link_up;
      if (pin_q.link_up != st.link_q) begin
         ev[EV_LINK] = 1'b1;
      end

      // Serial management frame, sampled on rising clock edges
      // Clock idles low and its edge flop resets low: no edge after reset
      next_st.mdc_q = pin_q.mdc;
      mdc_rise      = pin_q.mdc & ~st.mdc_q; // [RQ15]
      if (mdc_rise) begin
         unique case (st.ms)
            M_PRE: begin
               if (pin_q.mdio) begin
                  if (st.cnt != PREAMBLE_LEN) begin
                     next_st.cnt = st.cnt + 6'h01;
                  end
               end else if (st.cnt == PREAMBLE_LEN) begin // [RQ15]
                  next_st.ms  = M_HDR;
                  next_st.cnt = '0;
                  next_st.sh  = '0;
               end else begin
                  next_st.cnt = '0;
               end
            end
            M_HDR: begin
               next_st.sh = {st.sh[14:0], pin_q.mdio};
               if (st.cnt == HDR_LAST) begin
                  hdr = {st.sh[11:0], pin_q.mdio};
                  // Disabled port or foreign address stays silent
                  ok = hdr[12] & ~pin_q.mgmt_port_disable // [RQ8]
                     & (hdr[9:5] == PHY_ADDR) & ~st.ireset;
                  next_st.rd_ok = ok & (hdr[11:10] == OP_READ);
                  next_st.wr_ok = ok & (hdr[11:10] == OP_WRITE);
                  next_st.reg_a = hdr[4:0];
                  next_st.ms    = M_TA;
                  next_st.cnt   = '0;
                  if (ok && hdr[11:10] == OP_READ) begin
                     next_st.sh = mii_read(st, hdr[4:0]);
                     if (hdr[4:0] == MREG_IRQ_STAT) begin
                        next_st.pend = 1'b0; // [RQ13]
                     end
                  end
               end else begin
                  next_st.cnt = st.cnt + 6'h01;
               end
            end
            M_TA: begin
               if (st.cnt == '0) begin
                  // Second turnaround bit is driven low
                  if (st.rd_ok) begin
                     next_st.pins.mdio_oe = 1'b1; // [RQ11]
                     next_st.pins.mdio_o  = 1'b0;
                  end
                  next_st.cnt = 6'h01;
               end else begin
                  next_st.ms  = M_DATA;
                  next_st.cnt = '0;
                  if (st.rd_ok) begin
                     next_st.pins.mdio_o = st.sh[15];
                     next_st.sh          = {st.sh[14:0], 1'b0};
                  end
               end
            end
            M_DATA: begin
               if (st.rd_ok) begin
                  next_st.pins.mdio_o = st.sh[15];
                  next_st.sh          = {st.sh[14:0], 1'b0};
               end else begin
                  next_st.sh = {st.sh[14:0], pin_q.mdio};
               end
               if (st.cnt == DATA_LAST) begin
                  next_st.ms           = M_PRE;
                  next_st.cnt          = '0;
                  next_st.pins.mdio_oe = 1'b0; // [RQ11]
                  next_st.pins.mdio_o  = 1'b0;
                  ev[EV_FRAME]         = st.rd_ok | st.wr_ok;
                  wd = {st.sh[14:0], pin_q.mdio};
                  if (st.wr_ok) begin
                     unique case (st.reg_a)
                        MREG_CTRL: begin
                           next_st.rst_bit     = wd[CTRL_RST_BIT]; // [RQ14]
                           next_st.speed100    = wd[CTRL_SPEED_BIT]; // [RQ9]
                           next_st.full_duplex = wd[CTRL_DUPLEX_BIT];
                        end
                        MREG_IRQ_EN: begin
                           next_st.irq_en = wd[IRQ_EN_BIT];
                        end
                        default: begin
                           next_st.irq_en = st.irq_en;
                        end
                     endcase
                  end
               end else begin
                  next_st.cnt = st.cnt + 6'h01;
               end
            end
         endcase
      end

      // Straps rule during reset, and always while management is off
      if (st.ireset || pin_q.mgmt_port_disable) begin // [RQ9]
         next_st.speed100    = pin_q.strap_speed100;
         next_st.full_duplex = pin_q.strap_full_duplex;
      end
      if (st.ireset) begin
         next_st.irq_en = 1'b0;
         next_st.pend   = 1'b0;
      end else if (ev[EV_LINK]) begin
         next_st.pend = 1'b1; // set beats the register 19 read
      end

      // Open drain: only the enable moves, level stays low
      next_st.pins.mgmt_irq_n_o  = 1'b0;
      next_st.pins.mgmt_irq_n_oe = next_st.pend & next_st.irq_en; // [RQ12]

      // Bus slave: one wait cycle, then the access completes
      if (st.rsp.waitrequest) begin
         if (bus_i.read || bus_i.write) begin
            next_st.rsp.waitrequest = 1'b0;
            next_st.rsp.readdata    = '0;
            if (bus_i.read) begin
               unique case (bus_i.address)
                  BUS_STATUS: begin
                     next_st.rsp.readdata = 32'({st.pend, pin_q.mgmt_port_disable, st.ireset, st.link_q,
                                                 st.full_duplex, st.speed100, st.pins.crs, st.pins.col});
                  end
                  BUS_CFG: begin
                     next_st.rsp.readdata[CFG_SWRST_BIT] = st.sw_reset;
                  end
                  BUS_IRQ_STAT: begin
                     next_st.rsp.readdata = 32'(st.ev_stat);
                  end
                  BUS_IRQ_MASK: begin
                     next_st.rsp.readdata = 32'(st.ev_mask);
                  end
                  default: begin
                     next_st.rsp.readdata = '0;
                  end
               endcase
            end
         end
      end else begin
         next_st.rsp.waitrequest = 1'b1;
         if (bus_i.write) begin
            unique case (bus_i.address)
               BUS_CFG: begin
                  next_st.sw_reset = bus_i.writedata[CFG_SWRST_BIT];
               end
               BUS_IRQ_STAT: begin
                  next_st.ev_stat = st.ev_stat & ~bus_i.writedata[EV_W-1:0];
               end
               BUS_IRQ_MASK: begin
                  next_st.ev_mask = bus_i.writedata[EV_W-1:0];
               end
               default: begin
                  next_st.ev_mask = st.ev_mask;
               end
            endcase
         end
      end

      // New events after the clear, so a set is never lost
      next_st.ev_stat = next_st.ev_stat | ev;
      next_st.irq     = |(next_st.ev_stat & next_st.ev_mask);
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         st                 <= '0;
         st.rsp.waitrequest <= 1'b1;
         st.ireset          <= 1'b1;
      end else begin
         st <= next_st;
      end
   end

   // Outputs straight from the state register
   assign bus_o = st.rsp;
   assign irq_o = st.irq;
   assign mii_o = st.pins;
endmodule
`default_nettype wire

// file: rtl/phy_pkg.sv
// Package: constants and types for the PHY status and management block
//
// Operation
// [RQ1] The MAC changes the transmit error input only in step with the transmit clock the PHY supplies.
// [RQ2] The receive clock runs at 25 MHz at 100 Mb/s and at 2.5 MHz at 10 Mb/s.
// [RQ3] Collision goes high while a collision is seen and stays high for as long as it lasts.
// [RQ4] In full duplex the collision output stays low.
// [RQ5] In half duplex carrier sense is high while transmitting or receiving a packet.
// [RQ6] In full duplex carrier sense is high only while receiving.
// [RQ7] Carrier sense may rise at any time but falls only in step with the receive clock.
// [RQ8] While management is disabled, reads and writes on the management data line are ignored.
// [RQ9] The configuration straps set only the initial values; after reset the serial channel controls them. Code: straps rule while management is off.
// [RQ10] The station keeps the management clock at or below 8 MHz.
// [RQ11] The management data line is one shared serial line that station and PHY drive in turn.
// [RQ12] With interrupt enable bit 18.1 set, the PHY pulls the open-drain interrupt low on a status change.
// [RQ13] Reading register 19 releases the pending management interrupt.
// [RQ14] The reset pin is ORed with bit 0.15 and the reset cycle is stretched by about 258 us after release.
// [RQ15] Management frames use the clause 22 format, sampled on the rising management clock edge.
package phy_pkg;

   // Clocking
   localparam int CLK_HZ        = 50_000_000;
   localparam int RXCLK_FAST_HZ = 25_000_000;
   localparam int RXCLK_SLOW_HZ = 2_500_000;
   localparam logic [3:0] HALF_FAST = 4'(CLK_HZ / (2 * RXCLK_FAST_HZ));
   localparam logic [3:0] HALF_SLOW = 4'(CLK_HZ / (2 * RXCLK_SLOW_HZ));
   localparam int MDC_MAX_HZ    = 8_000_000;
   // Reset stretch, least time so rounded up
   localparam int RST_EXT_NS    = 258_000;
   localparam int RST_EXT_CYC   = (RST_EXT_NS * (CLK_HZ / 1_000_000) + 999) / 1000;

   // Serial management frame
   localparam logic [5:0] PREAMBLE_LEN = 6'h20;
   localparam logic [5:0] HDR_LAST     = 6'h0C;
   localparam logic [5:0] DATA_LAST    = 6'h0F;
   localparam logic [1:0] OP_READ      = 2'h2;
   localparam logic [1:0] OP_WRITE     = 2'h1;

   // Management register addresses and bits
   localparam logic [4:0] MREG_CTRL     = 5'h00;
   localparam logic [4:0] MREG_STAT     = 5'h01;
   localparam logic [4:0] MREG_IRQ_EN   = 5'h12;
   localparam logic [4:0] MREG_IRQ_STAT = 5'h13;
   localparam int CTRL_RST_BIT    = 15;
   localparam int CTRL_SPEED_BIT  = 13;
   localparam int CTRL_DUPLEX_BIT = 8;
   localparam int STAT_LINK_BIT   = 2;
   localparam int IRQ_EN_BIT      = 1;
   localparam int IRQ_PEND_BIT    = 2;

   // Bus register byte offsets
   localparam logic [3:0] BUS_STATUS   = 4'h0;
   localparam logic [3:0] BUS_CFG      = 4'h4;
   localparam logic [3:0] BUS_IRQ_STAT = 4'h8;
   localparam logic [3:0] BUS_IRQ_MASK = 4'hC;
   localparam int CFG_SWRST_BIT = 0;

   // Event bits, shared by status and mask
   localparam int EV_COL   = 0;
   localparam int EV_FRAME = 1;
   localparam int EV_LINK  = 2;
   localparam int EV_TXER  = 3;
   localparam int EV_RDONE = 4;
   localparam int EV_W     = 5;

   typedef struct packed {
      logic [3:0]  address;
      logic        read;
      logic        write;
      logic [31:0] writedata;
   } avs_req_t;

   typedef struct packed {
      logic [31:0] readdata;
      logic        waitrequest;
   } avs_rsp_t;

   // Pins from outside the clock domain
   typedef struct packed {
      logic mdc;
      logic mdio;
      logic mgmt_port_disable;
      logic rst_pin_n;
      logic tx_en;
      logic tx_er;
      logic rx_carrier;
      logic link_up;
      logic strap_speed100;
      logic strap_full_duplex;
   } pins_t;

   // Pins driven toward the MAC and station
   typedef struct packed {
      logic rx_clk;
      logic tx_clk;
      logic col;
      logic crs;
      logic mdio_o;
      logic mdio_oe;
      logic mgmt_irq_n_o;
      logic mgmt_irq_n_oe;
   } mii_out_t;

   typedef enum logic [1:0] {M_PRE, M_HDR, M_TA, M_DATA} mstate_t;

endpackage

// file: rtl/pin_sync.sv
// Two-stage synchroniser for a bundle of pin inputs
`timescale 1ns/100ps
`default_nettype none
module pin_sync #(
   parameter int W = 1
) (
   // Clock and reset
   input  wire logic         clk_i,
   input  wire logic         arst_n_i,
   // Data
   input  wire logic [W-1:0] d_i,
   output logic      [W-1:0] q_o
);
   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] q;
   } sync_t;

   sync_t st;
   sync_t next_st;

   // First stage feeds only the second
   always_comb begin
      next_st      = st;
      next_st.meta = d_i;
      next_st.q    = st.meta;
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign q_o = st.q;
endmodule
`default_nettype wire

// file: test/phy_mii_mgmt_sva.sv
// Assertion checker for the PHY status and management block
`timescale 1ns/100ps
`default_nettype none
module phy_mii_mgmt_chk
   import phy_pkg::*;
(
   // Clock and reset
   input  wire logic              clk_i,
   input  wire logic              arst_n_i,
   // Watched ports
   input  wire phy_pkg::avs_req_t bus_i,
   input  wire phy_pkg::avs_rsp_t bus_o,
   input  wire logic              irq_o,
   input  wire phy_pkg::pins_t    pins_i,
   input  wire phy_pkg::mii_out_t mii_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!arst_n_i);

   // Strap-driven duplex, only trusted while management is off
   logic col_in;
   logic hdx;
   logic fdx;
   assign col_in = pins_i.tx_en & pins_i.rx_carrier;
   assign hdx    = pins_i.mgmt_port_disable & ~pins_i.strap_full_duplex;
   assign fdx    = pins_i.mgmt_port_disable & pins_i.strap_full_duplex;

   bus_answer_a: assert property ((bus_i.read | bus_i.write) && bus_o.waitrequest |=> !bus_o.waitrequest)
      else $error("bus access not answered in one cycle");
   ack_pulse_a: assert property (!bus_o.waitrequest |=> bus_o.waitrequest)
      else $error("waitrequest low for more than one cycle");
   rxclk_fast_a: assert property ((pins_i.mgmt_port_disable && pins_i.strap_speed100) [*8] |->
      mii_o.rx_clk != $past(mii_o.rx_clk)) else $error("fast receive clock not toggling");
   col_hold_a: assert property ((hdx && col_in) [*6] |-> mii_o.col)
      else $error("collision output low during collision");
   col_fdx_a: assert property (fdx [*6] |-> !mii_o.col)
      else $error("collision shown in full duplex");
   crs_hdx_tx_a: assert property ((hdx && pins_i.tx_en) [*6] |-> mii_o.crs)
      else $error("carrier sense low while transmitting in half duplex");
   crs_fdx_tx_a: assert property ((fdx && pins_i.strap_speed100 && !pins_i.rx_carrier) [*8] |-> !mii_o.crs)
      else $error("carrier sense high without receive in full duplex");
   crs_fall_a: assert property ($fell(mii_o.crs) |-> $rose(mii_o.rx_clk))
      else $error("carrier sense fell off the receive clock");
   mdio_off_a: assert property (pins_i.mgmt_port_disable [*4] |-> !mii_o.mdio_oe)
      else $error("management line driven while disabled");
   irq_pin_a: assert property (mii_o.mgmt_irq_n_oe |-> !mii_o.mgmt_irq_n_o)
      else $error("interrupt pin driven high");

   // Main scenarios reached
   cover property ($rose(mii_o.col));
   cover property ($fell(mii_o.crs));
   cover property ($rose(mii_o.mdio_oe));
   cover property ($rose(mii_o.mgmt_irq_n_oe));
endmodule

bind phy_mii_mgmt phy_mii_mgmt_chk i_phy_mii_mgmt_chk (.clk_i(clk_i), .arst_n_i(arst_n_i), .bus_i(bus_i),
   .bus_o(bus_o), .irq_o(irq_o), .pins_i(pins_i), .mii_o(mii_o));
`default_nettype wire

// file: test/phy_mii_mgmt_tb_top.sv
// Testbench for the PHY status and management block
`timescale 1ns/100ps
`default_nettype none
module phy_mii_mgmt_tb_top;
   import phy_pkg::*;
   localparam int RST_CYC = 20;
   // Design and line signals
   logic              clk_i;
   logic              arst_n_i;
   logic              irq;
   logic              mpd, rstp, txen, txer, rxc, link, s100, sfd;
   logic              mdc, st_d, st_oe;
   wire logic         mdio;
   phy_pkg::avs_req_t bus;
   phy_pkg::avs_rsp_t rsp;
   phy_pkg::pins_t    pins;
   phy_pkg::mii_out_t mii;
   logic [31:0]       r;
   logic [15:0]       m;
   logic [4:0]        step [7];
   int                n_mismatch, tests_run, cyc, t0;

   // Pulled-up line: any enabled driver may pull it low
   assign mdio = (mii.mdio_oe ? mii.mdio_o : 1'b1) & (st_oe ? st_d : 1'b1);
   always_comb pins = '{mdc, mdio, mpd, rstp, txen, txer, rxc, link, s100, sfd};

   phy_mii_mgmt #(.PHY_ADDR(5'h00), .RST_EXT_CYCLES(RST_CYC)) i_phy_mii_mgmt (.clk_i(clk_i),
      .arst_n_i(arst_n_i), .bus_i(bus), .bus_o(rsp), .irq_o(irq), .pins_i(pins), .mii_o(mii));
   station_model i_station_model (.clk_i(clk_i), .mdio_i(mdio), .mdc_o(mdc), .mdio_o(st_d), .mdio_oe_o(st_oe));

   // Clock and hang guard
   always #10 clk_i = ~clk_i;
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_mismatch++;
         $display("[ERR] %0t timeout", $time);
         report_and_stop();
      end
   end

   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      tests_run++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   // Request held until waitrequest is seen low at an edge
   task automatic bus_xf(input logic wr, input logic [3:0] a, input logic [31:0] wd);
      int n;
      n = 0;
      @(posedge clk_i);
      bus <= '{a, !wr, wr, wd};
      @(posedge clk_i);
      while (rsp.waitrequest !== 1'b0 && n < 20) begin
         @(posedge clk_i);
         n++;
      end
      r = rsp.readdata;
      bus <= '{a, 1'b0, 1'b0, wd};
      chk({31'h0, rsp.waitrequest}, 32'h0, "bus answer");
   endtask

   // Stretch must be running now and end within the poll budget
   task automatic stretch_seen();
      bus_xf(1'b0, BUS_STATUS, 32'h0);
      chk({31'h0, r[5]}, 32'h1, "stretch running");
      for (int i = 0; i < 40; i++) begin
         bus_xf(1'b0, BUS_STATUS, 32'h0);
         if (r[5] === 1'b0)
            break;
      end
      chk({31'h0, r[5]}, 32'h0, "stretch end");
   endtask

   initial begin
      clk_i      = 1'b0;
      arst_n_i   = 1'b0;
      cyc        = 0;
      n_mismatch = 0;
      tests_run  = 0;
      bus        = '0;
      // Management off, pin reset idle, 100 Mb/s half duplex straps
      {mpd, rstp, txen, txer, rxc, link, s100, sfd} = 8'hC2;
      // Rows {full duplex, tx_en, rx_carrier, col, crs}
      step = '{5'h0F, 5'h09, 5'h00, 5'h1D, 5'h18, 5'h15, 5'h10};
      repeat (4) @(posedge clk_i);
      arst_n_i <= 1'b1;
      stretch_seen();
      bus_xf(1'b0, BUS_IRQ_STAT, 32'h0);
      chk(r, 32'h10, "reset done event");
      bus_xf(1'b0, BUS_IRQ_MASK, 32'h0);
      chk(r, 32'h0, "mask reset value");
      chk({31'h0, irq}, 32'h0, "masked irq");
      bus_xf(1'b0, 4'h2, 32'h0);
      chk(r, 32'h0, "unmapped read");
      bus_xf(1'b1, BUS_IRQ_MASK, 32'h10);
      repeat (3) @(posedge clk_i);
      chk({31'h0, irq}, 32'h1, "irq raised");
      bus_xf(1'b1, BUS_IRQ_STAT, 32'h10);
      repeat (3) @(posedge clk_i);
      chk({31'h0, irq}, 32'h0, "irq cleared");
      $display("test registers done");

      // Receive clock period, slow then fast
      for (int s = 0; s < 2; s++) begin
         @(posedge clk_i);
         s100 <= s[0];
         repeat (30) @(posedge clk_i);
         @(posedge mii.rx_clk);
         t0 = $time;
         @(posedge mii.rx_clk);
         chk(32'($time - t0), s ? 32'h28 : 32'h190, "rx_clk period");
      end
      $display("test clocks done");

      // Collision and carrier sense across duplex modes
      foreach (step[i]) begin
         @(posedge clk_i);
         {sfd, txen, rxc} <= step[i][4:2];
         repeat (12) @(posedge clk_i);
         chk({30'h0, mii.col, mii.crs}, {30'h0, step[i][1:0]}, "col crs");
      end
      txen <= 1'b1;
      @(posedge mii.tx_clk);
      txer <= 1'b1;
      repeat (8) @(posedge clk_i);
      {txen, txer} <= 2'h0;
      bus_xf(1'b0, BUS_IRQ_STAT, 32'h0);
      chk(r, 32'h09, "collision and tx error events");
      bus_xf(1'b1, BUS_IRQ_STAT, 32'h1F);
      $display("test line status done");

      // Management disabled, then enabled with straps moved
      i_station_model.xfer(OP_READ, 5'h00, MREG_CTRL, 16'h0, m);
      chk({16'h0, m}, 32'hFFFF, "disabled read");
      bus_xf(1'b0, BUS_STATUS, 32'h0);
      chk(r & 32'hCC, 32'h4C, "status under straps");
      @(posedge clk_i);
      mpd <= 1'b0;
      repeat (6) @(posedge clk_i);
      {s100, sfd} <= 2'h0;
      i_station_model.xfer(OP_READ, 5'h00, MREG_CTRL, 16'h0, m);
      chk({16'h0, m}, 32'h2100, "straps only initial");
      i_station_model.xfer(OP_WRITE, 5'h00, MREG_CTRL, 16'h0100, m);
      i_station_model.xfer(OP_READ, 5'h00, MREG_CTRL, 16'h0, m);
      chk({16'h0, m}, 32'h0100, "control write");
      i_station_model.xfer(OP_READ, 5'h01, MREG_CTRL, 16'h0, m);
      chk({16'h0, m}, 32'hFFFF, "other address ignored");
      bus_xf(1'b0, BUS_STATUS, 32'h0);
      chk(r & 32'hCC, 32'h08, "status under management");
      $display("test management done");

      // Interrupt pin on link change, released by status read
      i_station_model.xfer(OP_WRITE, 5'h00, MREG_IRQ_EN, 16'h0002, m);
      @(posedge clk_i);
      link <= 1'b1;
      repeat (8) @(posedge clk_i);
      chk({30'h0, mii.mgmt_irq_n_oe, mii.mgmt_irq_n_o}, 32'h2, "irq pin low");
      i_station_model.xfer(OP_READ, 5'h00, MREG_IRQ_STAT, 16'h0, m);
      chk({16'h0, m}, 32'h0004, "pending bit");
      repeat (8) @(posedge clk_i);
      chk({31'h0, mii.mgmt_irq_n_oe}, 32'h0, "irq pin released");
      bus_xf(1'b0, BUS_IRQ_STAT, 32'h0);
      chk(r, 32'h06, "frame and link events");
      $display("test interrupt pin done");

      // Soft reset bit, then reset pin
      i_station_model.xfer(OP_WRITE, 5'h00, MREG_CTRL, 16'h8000, m);
      stretch_seen();
      @(posedge clk_i);
      rstp <= 1'b0;
      repeat (4) @(posedge clk_i);
      rstp <= 1'b1;
      stretch_seen();
      $display("test resets done");
      report_and_stop();
   end
endmodule
`default_nettype wire

// file: test/station_model.sv
// Management station model driving the serial management line
`timescale 1ns/100ps
`default_nettype none
module station_model (
   // Clock
   input  wire logic clk_i,
   // Line side
   input  wire logic mdio_i,
   output logic      mdc_o,
   output logic      mdio_o,
   output logic      mdio_oe_o
);
   // Clock stands still low between frames
   initial begin
      mdc_o     = 1'b0;
      mdio_o    = 1'b1;
      mdio_oe_o = 1'b0;
   end

   // One frame, MSB first; eight cycles a bit keeps the clock under the limit
   task automatic xfer(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
                       input logic [15:0] wd, output logic [15:0] rd);
      logic [63:0] f;
      f  = {32'hFFFF_FFFF, 2'h1, op, pa, ra, 2'h2, wd};
      rd = 16'hFFFF;
      @(posedge clk_i);
      for (int i = 63; i >= 0; i--) begin
         if (i < 16)
            rd[i] = mdio_i;
         mdio_oe_o <= !(op == 2'h2 && i < 18);
         mdio_o    <= f[i];
         repeat (4) @(posedge clk_i);
         mdc_o <= 1'b1;
         repeat (4) @(posedge clk_i);
         mdc_o <= 1'b0;
      end
      mdio_oe_o <= 1'b0;
   endtask
endmodule
`default_nettype wire
